// ### src/lfd_regs.svh
// Register offsets, field positions, reset values and timing counts of the fault-diagnosis block.
`ifndef LFD_REGS_SVH
`define LFD_REGS_SVH
`define LFD_ADDR_W 8
`define LFD_ADDR_CONFIG 8'h00
`define LFD_ADDR_SP0 8'h04
`define LFD_ADDR_SP1 8'h08
`define LFD_ADDR_DIAG 8'h0C
`define LFD_ADDR_STATUS 8'h10
`define LFD_CFG_ENMASK 0
`define LFD_CFG_CHMASK 1
`define LFD_CFG_SEL 3
`define LFD_CFG_RESET 32'h0000_0000
`define LFD_SP_VAL_MSB 11
`define LFD_SP_EN 15
`define LFD_SP_RESET 16'h0000
`define LFD_SP_ZERO 12'h000
`define LFD_DG_OVC 0
`define LFD_DG_OT 2
`define LFD_DG_UV 4
`define LFD_DG_OLSB 6
`define LFD_DG_OFF 8
`define LFD_DG_PUMP 10
`define LFD_DG_VBAT 11
`define LFD_DG_CRC 12
`define LFD_DG_LSOV 13
`define LFD_DG_CLKF 15
`define LFD_ST_READY 0
`define LFD_ST_DRIVE 1
`define LFD_ST_CLKF 3
`define LFD_ST_ENPIN 4
`define LFD_ST_RSTPIN 5
`define LFD_OC_FILT_CYC 6'h1E
`define LFD_OLSB_DELAY_CYC 8192
`define LFD_READY_CYC 5'h10
`define LFD_CLK_TIMEOUT_CYC 6'h20
`define LFD_RESP_OKAY 2'h0
`define LFD_RESP_SLVERR 2'h2
`endif

// ### src/lfd_pkg.sv
// Types shared by the fault-diagnosis block and its bench.
package lfd_pkg;
  // Raw comparator and monitor levels of one channel.
  typedef struct packed {
    logic overcurrent;
    logic overtemp;
    logic below_openload;
    logic supply_under;
    logic supply_over;
    logic load_above_half;
  } lfd_chan_in_t;
  // Global pin and monitor levels.
  typedef struct packed {
    logic ext_clk;
    logic logic_supply_pins_under;
    logic vbat_over;
    logic pump_under;
    logic enable_pin;
    logic reset_input_low_n;
  } lfd_pins_t;
  // Everything that arrives from outside the clock domain.
  typedef struct packed {
    lfd_pins_t pins;
    lfd_chan_in_t [1:0] ch;
  } lfd_async_t;
  // Power stage and off-state current source controls of one channel.
  typedef struct packed {
    logic drive_on;
    logic pullup_on;
    logic pulldown_on;
  } lfd_chan_out_t;
endpackage

// ### src/lfd_core.sv
// Fault-diagnosis logic of a two-channel solenoid driver with an AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "lfd_regs.svh"
module lfd_core #(
  parameter int unsigned OLSB_DELAY = `LFD_OLSB_DELAY_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lfd_pkg::lfd_async_t async_in,
  input wire logic crc_result_valid,
  input wire logic crc_result_bad,
  output lfd_pkg::lfd_chan_out_t [1:0] chan_out,
  output logic device_ready,
  output logic fault_alert_out_o,
  output logic fault_alert_out_oe
);
  import lfd_pkg::*;

  // Byte-lane merge of a write into an old register value.
  function automatic logic [31:0] lfd_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address of a channel's setpoint register.
  function automatic logic [7:0] lfd_sp_addr(input int ch);
    return (ch == 0) ? `LFD_ADDR_SP0 : `LFD_ADDR_SP1;
  endfunction

  lfd_async_t sync1_r;
  lfd_async_t sync2_r;
  logic clk_d_r;
  logic [5:0] clk_cnt_r;
  logic clk_fault_r;
  logic [4:0] ready_cnt_r;
  logic ready_r;
  logic [31:0] cfg_r;
  logic [15:0] sp_r [2];
  logic ovc_flag_r [2];
  logic ot_flag_r [2];
  logic uv_flag_r [2];
  logic olsb_flag_r [2];
  logic drive_w [2];
  logic src_en_w [2];
  logic off_open_w [2];
  logic oc_trip_w [2];
  logic olsb_trip_w [2];
  logic pump_flag_r;
  logic vbat_flag_r;
  logic crc_flag_r;
  logic [31:0] diag_w;
  logic [31:0] status_w;
  logic alert_cond_w;
  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_fire_w;
  logic [31:0] wr_cfg_w;
  logic ar_fire_w;
  logic diag_rd_w;
  logic [31:0] rd_data_w;
  logic rd_ok_w;

  // Two-flop synchroniser for every pin and analog monitor level.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  // Clock pin supervision: too long without an edge is a clock fault.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      clk_d_r <= 1'b0;
      clk_cnt_r <= '0;
      clk_fault_r <= 1'b0;
    end else begin
      clk_d_r <= sync2_r.pins.ext_clk;
      if (sync2_r.pins.ext_clk != clk_d_r) begin
        clk_cnt_r <= '0;
        clk_fault_r <= 1'b0;
      end else if (clk_cnt_r == `LFD_CLK_TIMEOUT_CYC) begin
        clk_fault_r <= 1'b1;
      end else begin
        clk_cnt_r <= clk_cnt_r + 6'h01;
      end
    end
  end

  // Power-up delay before the device counts as ready to operate.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ready_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (ready_cnt_r == `LFD_READY_CYC) begin
      ready_r <= 1'b1;
    end else begin
      ready_cnt_r <= ready_cnt_r + 5'h01;
    end
  end

  // Write channel: address and data are taken in either order.
  assign wr_fire_w = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign wr_cfg_w = lfd_merge(cfg_r, w_data_r, w_strb_r);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      aw_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_r <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr_r <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_r <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_have_r & ~s_axi_bvalid;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      w_have_r <= 1'b0;
      s_axi_wready <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_r <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_r <= 1'b0;
    end else begin
      s_axi_wready <= ~w_have_r & ~s_axi_bvalid;
    end
  end

  // Write response; diagnosis and status are read only and answer an error.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LFD_RESP_OKAY;
    end else if (wr_fire_w) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_r == `LFD_ADDR_CONFIG || aw_addr_r == `LFD_ADDR_SP0 ||
                      aw_addr_r == `LFD_ADDR_SP1) ? `LFD_RESP_OKAY : `LFD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration register: masks and off-state current selects.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cfg_r <= `LFD_CFG_RESET;
    end else if (wr_fire_w && aw_addr_r == `LFD_ADDR_CONFIG) begin
      cfg_r <= wr_cfg_w;
    end
  end

  // Per-channel protection, setpoint and flag logic.
  for (genvar ch = 0; ch < 2; ch++) begin : ch_g
    logic [5:0] oc_cnt_r;
    logic [13:0] olsb_cnt_r;
    logic [31:0] sp_merge_w;
    logic hw_clr_w;
    lfd_chan_in_t in_w;
    assign in_w = sync2_r.ch[ch];
    assign sp_merge_w = lfd_merge({16'h0000, sp_r[ch]}, w_data_r, w_strb_r);
    // The channel drives with a non-zero enabled setpoint and no blocking supply fault.
    assign drive_w[ch] = (sp_r[ch][`LFD_SP_VAL_MSB:0] != `LFD_SP_ZERO) & sp_r[ch][`LFD_SP_EN] &
                         ~uv_flag_r[ch] & ~pump_flag_r & ~vbat_flag_r;
    assign src_en_w[ch] = (sp_r[ch][`LFD_SP_VAL_MSB:0] == `LFD_SP_ZERO) &
                          sp_r[ch][`LFD_SP_EN];
    // Pull-up exposes a pin that stays high, pull-down one that stays low.
    assign off_open_w[ch] = src_en_w[ch] &
                            (cfg_r[`LFD_CFG_SEL + ch] ? ~in_w.load_above_half
                                                      : in_w.load_above_half);
    assign oc_trip_w[ch] = drive_w[ch] & in_w.overcurrent &
                           (oc_cnt_r == `LFD_OC_FILT_CYC);
    assign olsb_trip_w[ch] = drive_w[ch] & in_w.below_openload &
                             (olsb_cnt_r == 14'(OLSB_DELAY - 1));
    assign hw_clr_w = oc_trip_w[ch] | olsb_trip_w[ch] | in_w.overtemp | sync2_r.pins.pump_under |
                      sync2_r.pins.vbat_over;

    // Overcurrent filter, counting only while the channel drives.
    always_ff @(posedge mclk) begin
      if (!nrst || !drive_w[ch] || !in_w.overcurrent) begin
        oc_cnt_r <= '0;
      end else if (oc_cnt_r != `LFD_OC_FILT_CYC) begin
        oc_cnt_r <= oc_cnt_r + 6'h01;
      end
    end

    // On-state open-load / bypass delay.
    always_ff @(posedge mclk) begin
      if (!nrst || !drive_w[ch] || !in_w.below_openload) begin
        olsb_cnt_r <= '0;
      end else if (!olsb_trip_w[ch]) begin
        olsb_cnt_r <= olsb_cnt_r + 14'h0001;
      end
    end

    // Setpoint: fault shutdown clears the value and wins over a software write.
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        sp_r[ch] <= `LFD_SP_RESET;
      end else if (hw_clr_w) begin
        sp_r[ch][`LFD_SP_VAL_MSB:0] <= `LFD_SP_ZERO;
      end else if (wr_fire_w && aw_addr_r == lfd_sp_addr(ch)) begin
        sp_r[ch] <= sp_merge_w[15:0];
      end
    end

    // Latched flags: a new set wins over a clear by the same read.
    always_ff @(posedge mclk) begin
      if (!nrst) begin
        ovc_flag_r[ch] <= 1'b0;
        ot_flag_r[ch] <= 1'b0;
        uv_flag_r[ch] <= 1'b0;
        olsb_flag_r[ch] <= 1'b0;
      end else begin
        ovc_flag_r[ch] <= oc_trip_w[ch] | (ovc_flag_r[ch] & ~diag_rd_w);
        ot_flag_r[ch] <= in_w.overtemp |
                         (ot_flag_r[ch] & ~diag_rd_w);
        uv_flag_r[ch] <= in_w.supply_under |
                         (uv_flag_r[ch] & ~diag_rd_w);
        olsb_flag_r[ch] <= olsb_trip_w[ch] |
                           (olsb_flag_r[ch] & ~(diag_rd_w & ~(drive_w[ch] &
                                                 in_w.below_openload)));
      end
    end
  end

  // Global latched flags; calibration errors never stop the channels.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pump_flag_r <= 1'b0;
      vbat_flag_r <= 1'b0;
      crc_flag_r <= 1'b0;
    end else begin
      pump_flag_r <= sync2_r.pins.pump_under | (pump_flag_r & ~diag_rd_w);
      vbat_flag_r <= sync2_r.pins.vbat_over | (vbat_flag_r & ~diag_rd_w);
      crc_flag_r <= (crc_result_valid & crc_result_bad) |
                    (crc_flag_r & ~diag_rd_w);
    end
  end

  // Diagnosis and status words as seen by a read.
  always_comb begin
    diag_w = '0;
    status_w = '0;
    for (int c = 0; c < 2; c++) begin
      diag_w[`LFD_DG_OVC + c] = ovc_flag_r[c];
      diag_w[`LFD_DG_OT + c] = ot_flag_r[c];
      diag_w[`LFD_DG_UV + c] = uv_flag_r[c];
      diag_w[`LFD_DG_OLSB + c] = olsb_flag_r[c];
      diag_w[`LFD_DG_OFF + c] = off_open_w[c];
      diag_w[`LFD_DG_LSOV + c] = sync2_r.ch[c].supply_over;
      status_w[`LFD_ST_DRIVE + c] = drive_w[c];
    end
    diag_w[`LFD_DG_PUMP] = pump_flag_r;
    diag_w[`LFD_DG_VBAT] = vbat_flag_r;
    diag_w[`LFD_DG_CRC] = crc_flag_r;
    diag_w[`LFD_DG_CLKF] = clk_fault_r;
    status_w[`LFD_ST_READY] = ready_r;
    status_w[`LFD_ST_CLKF] = clk_fault_r;
    status_w[`LFD_ST_ENPIN] = sync2_r.pins.enable_pin;
    status_w[`LFD_ST_RSTPIN] = sync2_r.pins.reset_input_low_n;
  end

  // Read decode at the address handshake.
  assign ar_fire_w = s_axi_arvalid & s_axi_arready;
  assign diag_rd_w = ar_fire_w & (s_axi_araddr == `LFD_ADDR_DIAG);

  always_comb begin
    rd_ok_w = 1'b1;
    unique case (s_axi_araddr)
      `LFD_ADDR_CONFIG: rd_data_w = cfg_r;
      `LFD_ADDR_SP0: rd_data_w = {16'h0000, sp_r[0]};
      `LFD_ADDR_SP1: rd_data_w = {16'h0000, sp_r[1]};
      `LFD_ADDR_DIAG: rd_data_w = diag_w;
      `LFD_ADDR_STATUS: rd_data_w = status_w;
      default: begin
        rd_data_w = '0;
        rd_ok_w = 1'b0;
      end
    endcase
  end

  // Read channel: the returned word is captured in the same edge that clears it.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `LFD_RESP_OKAY;
    end else if (ar_fire_w) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data_w;
      s_axi_rresp <= rd_ok_w ? `LFD_RESP_OKAY : `LFD_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= ~s_axi_rvalid;
    end
  end

  // Alert level from the unmasked fault sources; the pump, calibration and off-state flags never alert.
  always_comb begin
    alert_cond_w = ~ready_r | ~sync2_r.pins.reset_input_low_n | sync2_r.pins.logic_supply_pins_under |
                   clk_fault_r | vbat_flag_r | sync2_r.pins.vbat_over;
    alert_cond_w = alert_cond_w | (cfg_r[`LFD_CFG_ENMASK] & ~sync2_r.pins.enable_pin);
    for (int c = 0; c < 2; c++) begin
      alert_cond_w = alert_cond_w | sync2_r.ch[c].supply_over |
                     (cfg_r[`LFD_CFG_CHMASK + c] & (ovc_flag_r[c] | ot_flag_r[c] |
                      uv_flag_r[c] | olsb_flag_r[c]));
    end
  end

  // Open-drain alert: the data bit is always low, only the enable moves.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      fault_alert_out_o <= 1'b0;
      fault_alert_out_oe <= 1'b1;
      device_ready <= 1'b0;
    end else begin
      fault_alert_out_o <= 1'b0;
      fault_alert_out_oe <= alert_cond_w;
      device_ready <= ready_r;
    end
  end

  // Registered power-stage and current-source controls.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      chan_out <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        chan_out[c].drive_on <= drive_w[c];
        chan_out[c].pullup_on <= src_en_w[c] & ~cfg_r[`LFD_CFG_SEL + c];
        chan_out[c].pulldown_on <= src_en_w[c] & cfg_r[`LFD_CFG_SEL + c];
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_powerup_low;
    !ready_r |=> fault_alert_out_oe;
  endproperty
  a_powerup_low: assert property (p_powerup_low) else $error("alert not low before ready");

  property p_released;
    ready_r && !alert_cond_w |=> !fault_alert_out_oe && !fault_alert_out_o;
  endproperty
  a_released: assert property (p_released) else $error("alert not released");

  property p_en_mask;
    ready_r && cfg_r[`LFD_CFG_ENMASK] && !sync2_r.pins.enable_pin |=> fault_alert_out_oe;
  endproperty
  a_en_mask: assert property (p_en_mask) else $error("enable pin fault not signalled");

  property p_chan_mask;
    cfg_r[`LFD_CFG_CHMASK] && ovc_flag_r[0] |=> fault_alert_out_oe;
  endproperty
  a_chan_mask: assert property (p_chan_mask) else $error("channel flag not signalled");

  property p_oc_idle;
    !drive_w[0] |=> ch_g[0].oc_cnt_r == 6'h00;
  endproperty
  a_oc_idle: assert property (p_oc_idle) else $error("overcurrent counted while off");

  property p_oc_trip;
    oc_trip_w[0] |=> ovc_flag_r[0] && sp_r[0][`LFD_SP_VAL_MSB:0] == `LFD_SP_ZERO && !drive_w[0];
  endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("overcurrent shutdown missing");

  // The window starts at a quiet cycle, so the filter counter is known to begin at zero.
  property p_oc_filter;
    !(drive_w[0] && sync2_r.ch[0].overcurrent) ##1
      (drive_w[0] && sync2_r.ch[0].overcurrent) [*8] |-> !oc_trip_w[0];
  endproperty
  a_oc_filter: assert property (p_oc_filter) else $error("overcurrent acted too early");

  property p_ovc_clear;
    diag_rd_w && ovc_flag_r[0] && !oc_trip_w[0] |=> !ovc_flag_r[0];
  endproperty
  a_ovc_clear: assert property (p_ovc_clear) else $error("overcurrent flag not cleared");

  property p_olsb_trip;
    olsb_trip_w[0] |=> olsb_flag_r[0] && !drive_w[0] ##1 !chan_out[0].drive_on;
  endproperty
  a_olsb_trip: assert property (p_olsb_trip) else $error("open load shutdown missing");

  property p_src_off;
    sp_r[0][`LFD_SP_VAL_MSB:0] != `LFD_SP_ZERO |=> !chan_out[0].pullup_on &&
                                                   !chan_out[0].pulldown_on;
  endproperty
  a_src_off: assert property (p_src_off) else $error("current source on while driving");

  property p_pump;
    sync2_r.pins.pump_under |=> sp_r[0][`LFD_SP_VAL_MSB:0] == `LFD_SP_ZERO &&
                                sp_r[1][`LFD_SP_VAL_MSB:0] == `LFD_SP_ZERO && pump_flag_r;
  endproperty
  a_pump: assert property (p_pump) else $error("pump fault did not stop channels");

  property p_crc;
    crc_result_valid && crc_result_bad |=> crc_flag_r;
  endproperty
  a_crc: assert property (p_crc) else $error("calibration error not flagged");

  c_oc_shutdown: cover property (oc_trip_w[0] ##1 diag_rd_w);
  c_olsb_shutdown: cover property (olsb_trip_w[1]);
  c_alert_release: cover property (fault_alert_out_oe ##1 !fault_alert_out_oe);
endmodule // lfd_core
`default_nettype wire

// ### sim/lfd_env.sv
// Model of the pins and monitors that surround the fault-diagnosis block.
`timescale 1ns/1ps
`default_nettype none
module lfd_env
  import lfd_pkg::*;
(
  input wire lfd_pkg::lfd_async_t lvl,
  input wire logic alert_oe,
  output var lfd_pkg::lfd_async_t async_in,
  output logic alert_wire
);
  logic ext_clk = 1'b0;
  // The device clock pin runs free, offset so it never lines up with the system clock.
  initial begin
    #3;
    forever #80 ext_clk = ~ext_clk;
  end
  // Pins follow the bench's levels, with the device clock pin supplied here.
  always_comb begin
    async_in = lvl;
    async_in.pins.ext_clk = ext_clk;
  end
  // The shared alert line has a pull-up, so any enabled driver pulls it low.
  assign alert_wire = alert_oe ? 1'b0 : 1'b1;
endmodule // lfd_env
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the fault-diagnosis block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lfd_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  lfd_async_t lvl, async_in;
  logic crc_result_valid = 1'b0;
  logic crc_result_bad = 1'b0;
  lfd_chan_out_t [1:0] chan_out;
  logic device_ready, fault_alert_out_o, fault_alert_out_oe, alert_wire;
  int fails = 0;
  int comparisons = 0;

  lfd_core #(.OLSB_DELAY(64)) i_lfd_core (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .async_in, .crc_result_valid, .crc_result_bad,
    .chan_out, .device_ready, .fault_alert_out_o, .fault_alert_out_oe);
  lfd_env i_lfd_env (.lvl, .alert_oe(fault_alert_out_oe), .async_in, .alert_wire);

  // System clock at 50 MHz.
  always #10 mclk = ~mclk;

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tmo;
    fails++;
    $display("[ERR] bus wait expected answer seen timeout");
    test_done();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One write; address and data are released separately as each is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) tmo();
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  // One read, judged against the expected word and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) tmo();
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  // Power-up hold of the alert, then refused accesses.
  task automatic t_power;
    cyc(3);
    chk("alert", 32'h0, 32'(alert_wire));
    cyc(30);
    chk("alert", 32'h1, 32'(alert_wire));
    chk("ready", 32'h1, 32'(device_ready));
    chk("alert_o", 32'h0, 32'(fault_alert_out_o));
    rd(8'h20, 32'h0000_0000, 2'h2);
    wr(8'h20, 32'h0000_0001, 2'h2);
    wr(8'h0c, 32'h0000_ffff, 2'h2);
  endtask

  // Enable-pin mask decides whether a low enable pin alerts.
  task automatic t_mask;
    lvl.pins.enable_pin <= 1'b0;
    cyc(8);
    chk("alert", 32'h1, 32'(alert_wire));
    wr(8'h00, 32'h0000_0001, 2'h0);
    cyc(8);
    chk("alert", 32'h0, 32'(alert_wire));
    lvl.pins.enable_pin <= 1'b1;
    cyc(8);
    chk("alert", 32'h1, 32'(alert_wire));
    wr(8'h00, 32'h0000_0002, 2'h0);
  endtask

  // Overcurrent on a driving and an idle channel, restart, calibration error.
  task automatic t_ovc;
    wr(8'h04, 32'h0000_8100, 2'h0);
    cyc(8);
    chk("drive0", 32'h1, 32'(chan_out[0].drive_on));
    lvl.ch[0].overcurrent <= 1'b1;
    lvl.ch[1].overcurrent <= 1'b1;
    cyc(18);
    chk("drive0", 32'h1, 32'(chan_out[0].drive_on));
    cyc(30);
    chk("drive0", 32'h0, 32'(chan_out[0].drive_on));
    lvl.ch[0].overcurrent <= 1'b0;
    lvl.ch[1].overcurrent <= 1'b0;
    cyc(4);
    chk("alert", 32'h0, 32'(alert_wire));
    rd(8'h04, 32'h0000_8000, 2'h0);
    rd(8'h0c, 32'h0000_0001, 2'h0);
    rd(8'h0c, 32'h0000_0000, 2'h0);
    cyc(4);
    chk("alert", 32'h1, 32'(alert_wire));
    chk("drive0", 32'h0, 32'(chan_out[0].drive_on));
    wr(8'h04, 32'h0000_8100, 2'h0);
    cyc(8);
    chk("drive0", 32'h1, 32'(chan_out[0].drive_on));
    crc_result_valid <= 1'b1;
    crc_result_bad <= 1'b1;
    @(posedge mclk);
    crc_result_valid <= 1'b0;
    rd(8'h0c, 32'h0000_1000, 2'h0);
    chk("drive0", 32'h1, 32'(chan_out[0].drive_on));
    rd(8'h0c, 32'h0000_0000, 2'h0);
    wr(8'h04, 32'h0000_0000, 2'h0);
  endtask

  // Off-state source choice and the live off-state flag.
  task automatic t_off;
    wr(8'h00, 32'h0000_0010, 2'h0);
    wr(8'h08, 32'h0000_8000, 2'h0);
    cyc(8);
    chk("src1", 32'h1, 32'(chan_out[1]));
    lvl.ch[1].load_above_half <= 1'b0;
    cyc(8);
    rd(8'h0c, 32'h0000_0200, 2'h0);
    lvl.ch[1].load_above_half <= 1'b1;
    cyc(8);
    rd(8'h0c, 32'h0000_0000, 2'h0);
    wr(8'h00, 32'h0000_0000, 2'h0);
    cyc(8);
    chk("src1", 32'h2, 32'(chan_out[1]));
    wr(8'h08, 32'h0000_8001, 2'h0);
    cyc(8);
    chk("src1", 32'h4, 32'(chan_out[1]));
    wr(8'h08, 32'h0000_0001, 2'h0);
    cyc(8);
    chk("src1", 32'h0, 32'(chan_out[1]));
  endtask

  // Open load, pump undervoltage and overtemperature on channel 0.
  task automatic t_supply;
    wr(8'h04, 32'h0000_8100, 2'h0);
    lvl.ch[0].below_openload <= 1'b1;
    cyc(40);
    chk("drive0", 32'h1, 32'(chan_out[0].drive_on));
    cyc(40);
    chk("drive0", 32'h0, 32'(chan_out[0].drive_on));
    lvl.ch[0].below_openload <= 1'b0;
    rd(8'h0c, 32'h0000_0040, 2'h0);
    rd(8'h0c, 32'h0000_0000, 2'h0);
    wr(8'h04, 32'h0000_8100, 2'h0);
    cyc(8);
    chk("drive0", 32'h1, 32'(chan_out[0].drive_on));
    lvl.pins.pump_under <= 1'b1;
    cyc(8);
    chk("drive0", 32'h0, 32'(chan_out[0].drive_on));
    lvl.pins.pump_under <= 1'b0;
    cyc(4);
    rd(8'h04, 32'h0000_8000, 2'h0);
    wr(8'h04, 32'h0000_8100, 2'h0);
    cyc(8);
    chk("drive0", 32'h0, 32'(chan_out[0].drive_on));
    rd(8'h0c, 32'h0000_0400, 2'h0);
    cyc(4);
    chk("drive0", 32'h1, 32'(chan_out[0].drive_on));
    lvl.ch[0].overtemp <= 1'b1;
    cyc(8);
    chk("drive0", 32'h0, 32'(chan_out[0].drive_on));
    rd(8'h0c, 32'h0000_0004, 2'h0);
    lvl.ch[0].overtemp <= 1'b0;
    cyc(4);
    rd(8'h0c, 32'h0000_0004, 2'h0);
    rd(8'h0c, 32'h0000_0000, 2'h0);
  endtask

  // Reset for three cycles, then the scenarios in turn.
  initial begin
    lvl = '0;
    lvl.pins.enable_pin = 1'b1;
    lvl.pins.reset_input_low_n = 1'b1;
    lvl.ch[1].load_above_half = 1'b1;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    t_power();
    t_mask();
    t_ovc();
    t_off();
    t_supply();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
